// [pbc_consts.svh]
// Register offsets, field positions and reset values of the port and comparator block.
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

// I/O locations.
`define PBC_ADDR_CMP_CTRL   6'h08
`define PBC_ADDR_PIN_LEVELS 6'h16
`define PBC_ADDR_DIRECTION  6'h17
`define PBC_ADDR_LATCH      6'h18

// Comparator control and status fields.
`define PBC_BIT_POWER_OFF   7
`define PBC_BIT_RESULT      5
`define PBC_BIT_IRQ_FLAG    4
`define PBC_BIT_IRQ_ENABLE  3
`define PBC_BIT_EDGE_HI     1
`define PBC_BIT_EDGE_LO     0

// Reset values.
`define PBC_RST_BYTE        8'h00

// Serial programming pin positions.
`define PBC_PIN_SER_CLK     7
`define PBC_PIN_SER_DOUT    6
`define PBC_PIN_SER_DIN     5

`endif

// [pbc_pkg.sv]
// Types shared by the port and comparator block.
package pbc_pkg;

  // Comparator event selection.
  typedef enum logic [1:0] {
    PBC_EDGE_TOGGLE   = 2'b00,
    PBC_EDGE_RESERVED = 2'b01,
    PBC_EDGE_FALL     = 2'b10,
    PBC_EDGE_RISE     = 2'b11
  } pbc_edge_e;

  // One byte of register data.
  typedef logic [7:0] pbc_byte_t;

endpackage : pbc_pkg

// [pbc_sync.sv]
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module pbc_sync
  import pbc_pkg::*;
#(
  parameter int WIDTH = 9
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Raw and synchronised levels.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by the second.

  // Both stages clear on reset so the reads start from a known value.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pbc_sync

// [pbc_port_cmp.sv]
// Eight-bit general-purpose port with analog comparator control logic.
//
// Functional notes
// - Result bit five mirrors comparator output, read-only.
// - Power-off bit seven switches comparator off.
// - Bits six and two always read zero.
// - Flag sets on selected comparator output event.
// - Flag clears when interrupt vector executes.
// - Writing one clears flag; zero leaves it.
// - Request needs flag, enable and global enable.
// - Mode: toggle, reserved, falling, rising edge.
// - Latch, direction, pin-level at three locations.
// - Latch reads stored; pin-level reads live pins.
// - Direction one drives pin from latch.
// - Pull-up only for inputs with latch one.
// - All eight pins behave identically.
// - Pins 7,6,5 carry serial clock, data.
// - Pin inputs pass through synchronising latches.
`timescale 1ns/1ps
`include "pbc_consts.svh"
module pbc_port_cmp
  import pbc_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // CPU I/O access.
  input  wire logic [5:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // CPU interrupt system.
  input  wire logic       cpu_global_irq_enable,
  input  wire logic       cmp_vector_taken,
  output logic            cmp_irq_req,
  // Port pins.
  input  wire logic [7:0] port_pin_in,
  output logic      [7:0] port_pin_out,
  output logic      [7:0] port_pin_oe,
  output logic      [7:0] port_pullup_en,
  // Analog comparator.
  input  wire logic       comparator_raw,
  output logic            comparator_power_off,
  // Serial programming lines.
  output logic            ser_clk_in,
  output logic            ser_data_in,
  input  wire logic       ser_data_out,
  input  wire logic       ser_prog_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0] port_output_latch_q;     // Output latch, also pull-up select.
  logic [7:0] port_direction_q;        // One makes the pin an output.
  logic       comparator_power_off_q;  // Comparator powered down.
  logic       comparator_irq_flag_q;   // Sticky event flag.
  logic       comparator_irq_enable_q; // Local interrupt enable.
  logic [1:0] edge_sel_q;              // Event selection.
  logic       cmp_prev_q;              // Previous comparator sample.
  logic [7:0] pins_sync;               // Synchronised pin levels.
  logic       cmp_sync;                // Synchronised comparator output.
  logic       cmp_event;               // Selected event seen this cycle.
  logic [7:0] rdata_d;                 // Read mux output.

  // Decode of a single I/O location, used for every register.
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] loc);
    hit = (addr == loc);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers.

  pbc_sync #(.WIDTH(9)) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in ({comparator_raw, port_pin_in}),
    .sync_out ({cmp_sync, pins_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Port registers.

  // Latch and direction are plain read/write bytes; reset leaves all
  // pins as floating inputs.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      port_output_latch_q <= `PBC_RST_BYTE;
      port_direction_q    <= `PBC_RST_BYTE;
    end else if (io_wr) begin
      if (hit(io_addr, `PBC_ADDR_LATCH)) begin
        port_output_latch_q <= io_wdata;
      end
      if (hit(io_addr, `PBC_ADDR_DIRECTION)) begin
        port_direction_q <= io_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, one identical slice per pin.

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign port_pin_oe[gi]    = port_direction_q[gi];
      assign port_pin_out[gi]   = port_output_latch_q[gi];
      assign port_pullup_en[gi] = ~port_direction_q[gi] & port_output_latch_q[gi];
    end
  endgenerate

  // serial programming pins
  // Pin six is never overridden here, not even while programming runs;
  // its direction and latch stay under software control.
  assign ser_clk_in  = pins_sync[`PBC_PIN_SER_CLK];
  assign ser_data_in = pins_sync[`PBC_PIN_SER_DIN];

  ////////////////////////////////////////////////////////////////////////////
  // Comparator control.

  // Control bits; software writes to the flag position only ever clear.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      comparator_power_off_q  <= 1'b0;
      comparator_irq_enable_q <= 1'b0;
      edge_sel_q              <= 2'b00;
    end else if (io_wr && hit(io_addr, `PBC_ADDR_CMP_CTRL)) begin
      comparator_power_off_q  <= io_wdata[`PBC_BIT_POWER_OFF];
      comparator_irq_enable_q <= io_wdata[`PBC_BIT_IRQ_ENABLE];
      edge_sel_q <= {io_wdata[`PBC_BIT_EDGE_HI], io_wdata[`PBC_BIT_EDGE_LO]};
    end
  end

  assign comparator_power_off = comparator_power_off_q;

  // Previous sample for edge detection; taken from the second stage only.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_prev_q <= cmp_sync;
    end
  end

  // edges from consecutive samples
  // The reserved code flags nothing; events still count while the comparator is powered down.
  always_comb begin
    cmp_event = 1'b0;
    unique case (pbc_edge_e'(edge_sel_q))
      PBC_EDGE_TOGGLE:   cmp_event = cmp_sync ^ cmp_prev_q;
      PBC_EDGE_RESERVED: cmp_event = 1'b0;
      PBC_EDGE_FALL:     cmp_event = ~cmp_sync & cmp_prev_q;
      PBC_EDGE_RISE:     cmp_event = cmp_sync & ~cmp_prev_q;
    endcase
  end

  // Flag: a new event wins over a clear arriving in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      comparator_irq_flag_q <= 1'b0;
    end else if (cmp_event) begin
      comparator_irq_flag_q <= 1'b1;
    end else if (cmp_vector_taken) begin
      comparator_irq_flag_q <= 1'b0;
    end else if (io_wr && hit(io_addr, `PBC_ADDR_CMP_CTRL)
                 && io_wdata[`PBC_BIT_IRQ_FLAG]) begin
      comparator_irq_flag_q <= 1'b0;
    end
  end

  // software masks irq first, so no glitch filter here
  // mode change relies on software masking
  assign cmp_irq_req = comparator_irq_flag_q & comparator_irq_enable_q
                       & cpu_global_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  // Unmapped locations return zero.
  always_comb begin
    rdata_d = 8'h00;
    if (hit(io_addr, `PBC_ADDR_CMP_CTRL)) begin
      rdata_d[`PBC_BIT_POWER_OFF]  = comparator_power_off_q;
      rdata_d[`PBC_BIT_RESULT]     = cmp_sync;
      rdata_d[`PBC_BIT_IRQ_FLAG]   = comparator_irq_flag_q;
      rdata_d[`PBC_BIT_IRQ_ENABLE] = comparator_irq_enable_q;
      rdata_d[`PBC_BIT_EDGE_HI]    = edge_sel_q[1];
      rdata_d[`PBC_BIT_EDGE_LO]    = edge_sel_q[0];
    end else if (hit(io_addr, `PBC_ADDR_PIN_LEVELS)) begin
      rdata_d = pins_sync;
    end else if (hit(io_addr, `PBC_ADDR_DIRECTION)) begin
      rdata_d = port_direction_q;
    end else if (hit(io_addr, `PBC_ADDR_LATCH)) begin
      rdata_d = port_output_latch_q;
    end
  end

  // Read data registered: answer one cycle after io_rd.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= rdata_d;
    end
  end

  // ser_data_out and ser_prog_active are taken by the pin pad mux outside;
  // this block only exposes the synchronised serial inputs.
  logic unused_ser;
  assign unused_ser = ser_data_out & ser_prog_active;

endmodule : pbc_port_cmp

// [pbc_pin_model.sv]
// Model of the pads and the board around the port pins.
`timescale 1ns/1ps
module pbc_pin_model (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Pad controls from the port.
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  // Board drivers.
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // Resolved pin levels.
  output logic      [7:0] pin_level
);
  logic [7:0] float_q;  // A floating pin shows the inverse of its last level.

  // Undriven pads wander every cycle, so a missing pull-up cannot pass unseen.
  always_ff @(posedge sys_clk) begin
    float_q <= sys_rst ? 8'h5a : ~pin_level;
  end

  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                   | (~pin_oe & ~ext_en & (pullup_en | float_q));
endmodule : pbc_pin_model

// [pbc_port_cmp_checker.sv]
// Port and comparator checker, bound to the pbc_port_cmp module.
`timescale 1ns/1ps
module pbc_port_cmp_checker (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic [5:0] io_addr,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       cpu_global_irq_enable,
  input wire logic       cmp_vector_taken,
  input wire logic       cmp_irq_req,
  input wire logic [7:0] port_pin_in,
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe,
  input wire logic [7:0] port_pullup_en,
  input wire logic       comparator_raw,
  input wire logic       comparator_power_off,
  input wire logic       ser_clk_in,
  input wire logic       ser_data_in
);
  logic [2:0] settle_q;  // Masks checks until the synchronisers hold real samples.

  // Count the cycles since reset release.
  always_ff @(posedge sys_clk) begin
    settle_q <= sys_rst ? 3'b111 : {settle_q[1:0], 1'b0};
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || settle_q != 3'b000);

  sequence rd_at(logic [5:0] a);
    io_rd && io_addr == a;
  endsequence

  dir_write_a: assert property (io_wr && io_addr == 6'h17 |=>
    port_pin_oe == $past(io_wdata)) else $error("direction write lost");
  latch_write_a: assert property (io_wr && io_addr == 6'h18 |=>
    port_pin_out == $past(io_wdata)) else $error("latch write lost");
  pullup_ctl_a: assert property (
    port_pullup_en == (~port_pin_oe & port_pin_out)) else $error("bad pull-up");
  rsvd_zero_a: assert property (rd_at(6'h08) |=>
    io_rdata[6] == 1'b0 && io_rdata[2] == 1'b0) else $error("reserved bit set");
  pin_read_a: assert property (rd_at(6'h16) ##0 $stable(port_pin_in)
    && port_pin_in == $past(port_pin_in, 2) |=> io_rdata == $past(port_pin_in))
    else $error("pin read wrong");
  power_off_a: assert property (io_wr && io_addr == 6'h08 |=>
    comparator_power_off == $past(io_wdata[7])) else $error("power-off wrong");
  irq_gate_a: assert property (cmp_irq_req |-> cpu_global_irq_enable)
    else $error("request without global enable");
  vector_clr_a: assert property ($stable(comparator_raw) [*3] ##0
    cmp_vector_taken |=> !cmp_irq_req) else $error("vector left flag");
  ser_pins_a: assert property (ser_clk_in == $past(port_pin_in[7], 2)
    && ser_data_in == $past(port_pin_in[5], 2)) else $error("serial pin wrong");
endmodule : pbc_port_cmp_checker

bind pbc_port_cmp pbc_port_cmp_checker chk_u (.*);

// [tb.sv]
// Self-checking bench for the port and comparator block.
`timescale 1ns/1ps
module tb;
  logic sys_clk = 0, sys_rst = 1, io_wr = 0, io_rd = 0, cpu_global_irq_enable = 0;
  logic cmp_vector_taken = 0, comparator_raw = 0, ser_data_out = 0, ser_prog_active = 0;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00, ext_val = 8'h00, ext_en = 8'h00, m_dir, m_lat;
  logic [7:0] io_rdata, port_pin_in, port_pin_out, port_pin_oe, port_pullup_en;
  logic cmp_irq_req, comparator_power_off, ser_clk_in, ser_data_in, m_flag;
  int err_total = 0, total_checks = 0, cyc = 0, m;

  pbc_port_cmp dut_u (.*);
  pbc_pin_model pins_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_out(port_pin_out),
    .pin_oe(port_pin_oe), .pullup_en(port_pullup_en), .ext_val(ext_val),
    .ext_en(ext_en), .pin_level(port_pin_in));

  always #20 sys_clk = ~sys_clk;

  task results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // A hang is cut short well past the expected run length.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr <= a; io_wdata <= d; io_wr <= 1'b1;
    @(posedge sys_clk);
    io_wr <= 1'b0;
  endtask : wr

  // Read data lands on the same edge that takes the strobe.
  task rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] mk);
    @(posedge sys_clk);
    io_addr <= a; io_rd <= 1'b1;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    #1 chk(io_rdata & mk, e & mk);
  endtask : rd

  task settle(input logic v);
    comparator_raw <= v;
    repeat (4) @(posedge sys_clk);
  endtask : settle

  initial begin
    void'($urandom(34));
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(6'h08, 8'h00, 8'hff);
    rd(6'h17, 8'h00, 8'hff);
    rd(6'h18, 8'h00, 8'hff);
    rd(6'h20, 8'h00, 8'hff);
    repeat (12) begin
      m_dir = 8'($urandom);
      m_lat = 8'($urandom);
      @(posedge sys_clk);
      ext_val <= 8'($urandom);
      ext_en <= 8'($urandom);
      wr(6'h17, m_dir);
      wr(6'h18, m_lat);
      wr(6'h16, ~m_lat);
      repeat (2) @(posedge sys_clk);
      chk(port_pin_oe, m_dir);
      chk(port_pin_out, m_lat);
      chk(port_pullup_en, ~m_dir & m_lat);
      rd(6'h17, m_dir, 8'hff);
      rd(6'h18, m_lat, 8'hff);
      // Floating pins (input, no board driver, no pull-up) wander, so they are masked.
      rd(6'h16, (m_dir & m_lat) | (~m_dir & ext_en & ext_val) | (~m_dir & ~ext_en & m_lat),
         ~(~m_dir & ~ext_en & ~m_lat));
    end
    for (m = 0; m < 4; m++) begin
      wr(6'h08, 8'(m));
      wr(6'h08, 8'h18 | 8'(m));
      cpu_global_irq_enable <= m[0];
      settle(1'b1);
      m_flag = (m == 0 || m == 3);
      rd(6'h08, {3'b001, m_flag, 2'b10, 2'(m)}, 8'hff);
      chk({7'h00, cmp_irq_req}, {7'h00, m_flag & m[0]});
      wr(6'h08, 8'h18 | 8'(m));
      settle(1'b0);
      m_flag = (m == 0 || m == 2);
      rd(6'h08, {3'b000, m_flag, 2'b10, 2'(m)}, 8'hff);
    end
    wr(6'h08, 8'h02);
    wr(6'h08, 8'h1a);
    settle(1'b1);
    settle(1'b0);
    wr(6'h08, 8'h0a);
    rd(6'h08, 8'h1a, 8'hff);
    @(posedge sys_clk);
    cmp_vector_taken <= 1'b1;
    @(posedge sys_clk);
    cmp_vector_taken <= 1'b0;
    rd(6'h08, 8'h0a, 8'hff);
    wr(6'h08, 8'h00);
    wr(6'h08, 8'h80);
    rd(6'h08, 8'h80, 8'hff);
    chk({7'h00, comparator_power_off}, 8'h01);
    results();
  end
endmodule : tb
